// File: rtl/smc_chain_port.sv
`timescale 1ns/10ps
// Operation
// - chip select frames own and downward serial data, not the upward relays
// - sample input bits on falling clock
// - falling convert-start edge starts conversion
// - serial request starts conversion when pin high
// - requested conversion starts on select rising
// - output results or registers serially
// - change output bit on rising clock
// - limit flag shows over/undervoltage
// - relay upper alert downward, master to host
// - forward upper chain data downward
// - slave sends data on lower chain output
// - relay convert-start upward
// - repeat serial input upward
// - repeat serial clock upward
// - repeat chip select upward
// - repeat power-down upward
// - enter power-down on power-down input
// - role input high means master
module smc_chain_port
  import smc_pkg::*;
#(
  parameter int BITS = SMC_FRAME_BITS
) (
  // core clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  // role strap
  input  wire logic            master_sel,
  // host or lower-chain serial side (link clock domain; limit flag registered on ref_clk)
  input  wire logic            sclk,
  input  wire logic            cs_n,
  input  wire logic            sdi,
  output logic                 sdo,
  output logic                 limit_flag_out,
  // control pins
  input  wire logic            convert_start_in,
  input  wire logic            power_down_in,
  // chain toward the device above
  output logic                 chain_clock_up_out,
  output logic                 chain_select_up_out,
  output logic                 chain_data_up_out,
  output logic                 convert_start_up_out,
  output logic                 power_down_up_out,
  input  wire logic            chain_data_up_in,
  input  wire logic            chain_limit_up_in,
  // chain toward the device below
  output logic                 chain_data_down_out,
  output logic                 chain_limit_down_out,
  // core side
  input  wire logic            local_limit,
  input  wire logic [BITS-1:0] result_word,
  input  wire logic [BITS-1:0] reg_word,
  output logic                 conv_start,
  output logic                 power_down,
  output logic [BITS-1:0]      write_word,
  output logic                 write_valid
);
  // ---------- link domain ----------
  logic [BITS-1:0] rx_word;
  logic            rx_toggle;
  logic            own_sdo;
  logic [BITS-1:0] tx_word;
  logic            read_sel_q;

  // read selection sits in the core domain and changes when a word is taken, which can be mid-frame
  assign tx_word = read_sel_q ? reg_word : result_word;

  smc_shift #(
    .BITS (BITS)
  ) u_shift (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .rst_n     (reset_n),
    .sdi       (sdi),
    .tx_word   (tx_word),
    .rx_word   (rx_word),
    .rx_toggle (rx_toggle),
    .sdo       (own_sdo)
  );

  // ---------- synchronisers into ref_clk ----------
  logic [5:0] raw_in;
  logic [5:0] sync_in;
  // select and convert-start pass inverted, so the reset value is their idle level
  assign raw_in = {rx_toggle, ~cs_n, ~convert_start_in, power_down_in,
                   chain_limit_up_in, master_sel};

  smc_sync #(
    .W (6)
  ) u_sync (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .d     (raw_in),
    .q     (sync_in)
  );

  wire tog_s    = sync_in[5];
  wire cs_n_s   = ~sync_in[4];
  wire cnv_s    = ~sync_in[3];
  wire pd_s     = sync_in[2];
  wire lim_up_s = sync_in[1];
  wire master_s = sync_in[0];

  // ---------- core domain ----------
  logic            tog_q;
  logic            cs_n_q;
  logic            cnv_q;
  logic            conv_req_q;
  logic [BITS-1:0] write_word_q;
  smc_frame_e      frame_q;
  smc_frame_e      frame_d;

  // toggle flips once per full frame
  wire word_evt  = tog_s ^ tog_q;
  wire word_take = word_evt & (frame_q == SMC_SHIFT);
  wire cs_rise   = cs_n_s & ~cs_n_q;
  wire cnv_fall  = ~cnv_s & cnv_q;
  // an early cs rise can land in the same cycle as the word itself
  wire conv_hit  = conv_req_q | (word_take & rx_word[SMC_CONV_REQ_BIT]);
  // a permanently high pin never falls, so serial start stays available
  wire req_start = cs_rise & conv_hit;
  wire alert_any = local_limit | lim_up_s;

  always_comb begin
    frame_d = frame_q;
    case (frame_q)
      SMC_IDLE:  if (!cs_n_s) frame_d = SMC_SHIFT;
      SMC_SHIFT: begin
        if (word_evt) frame_d = SMC_DONE;
        else if (cs_n_s) frame_d = SMC_IDLE;
      end
      SMC_DONE:  if (cs_n_s) frame_d = SMC_IDLE;
      default:   frame_d = SMC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_q <= SMC_IDLE;
      tog_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      cnv_q   <= 1'b1;
    end else begin
      frame_q <= frame_d;
      tog_q   <= tog_s;
      cs_n_q  <= cs_n_s;
      cnv_q   <= cnv_s;
    end
  end

  // only a complete frame updates the command word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_word_q <= SMC_WORD_RST;
      conv_req_q   <= 1'b0;
      read_sel_q   <= 1'b0;
      write_valid  <= 1'b0;
    end else begin
      write_valid <= word_take;
      if (word_take) begin
        write_word_q <= rx_word;
        conv_req_q   <= rx_word[SMC_CONV_REQ_BIT] & ~cs_rise;
        read_sel_q   <= rx_word[SMC_READ_SEL_BIT];
      end else if (req_start) begin
        conv_req_q   <= 1'b0;
      end
    end
  end

  assign write_word = write_word_q;

  // registered status outputs: core side, host flag and downward alert
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_start     <= 1'b0;
      power_down     <= 1'b0;
      limit_flag_out <= 1'b0;
      chain_limit_down_out <= 1'b0;
    end else begin
      conv_start     <= cnv_fall | req_start;
      power_down     <= pd_s;
      limit_flag_out <= master_s & alert_any;
      chain_limit_down_out <= ~master_s & alert_any;
    end
  end

  // ---------- pass-through pins ----------
  // upward relays are pure wires: any resampling would skew clock against data
  assign chain_clock_up_out   = sclk;
  assign chain_select_up_out  = cs_n;
  assign chain_data_up_out    = sdi;
  assign convert_start_up_out = convert_start_in;
  assign power_down_up_out    = power_down_in;

  // downward data: own word then the stack above, framed by cs
  logic frame_own;
  assign frame_own = ~cs_n;
  wire  down_bit   = own_sdo | (frame_own & chain_data_up_in);
  // role strap sampled raw: it is tied, not toggled, during operation
  assign sdo                 = master_sel & down_bit;
  assign chain_data_down_out = ~master_sel & down_bit;
endmodule

// File: rtl/smc_pkg.sv
package smc_pkg;
  // frame geometry
  localparam int SMC_FRAME_BITS = 32;
  localparam int SMC_CNT_W      = 6;
  localparam logic [SMC_CNT_W-1:0] SMC_CNT_RST = 6'h00;
  // write word fields: bit 31 requests a conversion at frame end, bit 30 selects readback
  localparam int SMC_CONV_REQ_BIT = 31;
  localparam int SMC_READ_SEL_BIT = 30;
  localparam logic [31:0] SMC_WORD_RST = 32'h0000_0000;
  // one-cycle pulse length for conversion starts on ref_clk
  localparam int SMC_START_PULSE_CYC = 1;
  typedef enum logic [1:0] {
    SMC_IDLE,
    SMC_SHIFT,
    SMC_DONE
  } smc_frame_e;
endpackage

// File: rtl/smc_shift.sv
`timescale 1ns/10ps
// link-domain shifter: input captured on falling sclk, output changed on rising sclk
module smc_shift
  import smc_pkg::*;
#(
  parameter int BITS = SMC_FRAME_BITS
) (
  input  wire logic            sclk,
  input  wire logic            cs_n,
  input  wire logic            rst_n,
  input  wire logic            sdi,
  input  wire logic [BITS-1:0] tx_word,
  output logic      [BITS-1:0] rx_word,
  output logic                 rx_toggle,
  output logic                 sdo
);
  logic [BITS-1:0]      in_q;
  logic [SMC_CNT_W-1:0] nbit_q;
  logic [BITS-1:0]      out_q;
  logic                 first_q;

  // cs high acts as async reset, so nothing depends on sclk outside a frame
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      in_q   <= '0;
      nbit_q <= SMC_CNT_RST;
    end else begin
      in_q   <= {in_q[BITS-2:0], sdi};
      nbit_q <= nbit_q + 6'h01;
    end
  end

  // word handed over on the 32nd falling edge by flipping the toggle;
  // cs does not clear either, so an early cs rise cannot erase the hand-over
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_toggle <= 1'b0;
      rx_word   <= '0;
    end else if (!cs_n && nbit_q == 6'(BITS - 1)) begin
      rx_toggle <= ~rx_toggle;
      rx_word   <= {in_q[BITS-2:0], sdi};
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_q   <= '0;
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
      out_q   <= first_q ? tx_word : {out_q[BITS-2:0], 1'b0};
    end
  end

  assign sdo = ~cs_n & out_q[BITS-1];
endmodule

// File: rtl/smc_sync.sv
`timescale 1ns/10ps
// two-flop level synchroniser; first stage is read only by the second
module smc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: verification/smc_chain_port_monitor.sv
`timescale 1ns/10ps
module smc_chain_port_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // inputs
  input wire logic master_sel,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic convert_start_in,
  input wire logic power_down_in,
  input wire logic chain_limit_up_in,
  input wire logic local_limit,
  // outputs
  input wire logic sdo,
  input wire logic limit_flag_out,
  input wire logic chain_clock_up_out,
  input wire logic chain_select_up_out,
  input wire logic chain_limit_down_out,
  input wire logic conv_start,
  input wire logic power_down
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire al_in = local_limit | chain_limit_up_in;
  // synchronised levels are judged only after the inputs sat still
  sequence al_calm; ($stable(al_in) && $stable(master_sel)) [*6]; endsequence
  sequence pd_calm; $stable(power_down_in) [*6]; endsequence
  clk_up_a: assert property (chain_clock_up_out == sclk) else $error("sclk");
  sel_up_a: assert property (chain_select_up_out == cs_n) else $error("cs");
  conv_pin_a: assert property ($fell(convert_start_in) |-> ##[2:5] conv_start)
    else $error("start");
  conv_once_a: assert property (conv_start |=> !conv_start) else $error("pulse");
  pd_pin_a: assert property (pd_calm |-> power_down == power_down_in)
    else $error("pd");
  host_alert_a: assert property (al_calm |-> limit_flag_out == (master_sel && al_in))
    else $error("flag");
  down_alert_a: assert property
    (al_calm |-> chain_limit_down_out == (!master_sel && al_in)) else $error("alert");
  slave_quiet_a: assert property (!master_sel |-> !sdo) else $error("sdo");
endmodule

bind smc_chain_port smc_chain_port_monitor u_mon (.*);

// File: verification/smc_upper_model.sv
`timescale 1ns/10ps
module smc_upper_model #(
  parameter logic [31:0] WORD = 32'h5A5A_0FF0
) (
  // chain from below
  input  wire logic chain_clock_up_out,
  input  wire logic chain_select_up_out,
  input  wire logic alert_up,
  // chain toward below
  output logic      chain_data_up_in,
  output logic      chain_limit_up_in
);
  int n = 0;
  initial chain_data_up_in = 1'b0;
  // own word follows the lower 32 bits; a released line shows the inverse bit
  always @(posedge chain_clock_up_out or posedge chain_select_up_out) begin
    if (chain_select_up_out) begin
      n <= 0;
      chain_data_up_in <= ~chain_data_up_in;
    end else begin
      n <= n + 1;
      chain_data_up_in <= (n >= 32 && n < 64) ? WORD[63-n] : 1'b0;
    end
  end
  assign chain_limit_up_in = alert_up;
endmodule

// File: verification/tb.sv
`timescale 1ns/10ps
module tb;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %0t mismatch", $time); end end
  localparam logic [31:0] UP_W = 32'hA5C3_0F96;
  logic ref_clk = 0, reset_n = 0, master_sel = 1, sclk = 0, cs_n = 1, sdi = 0, alert_up = 0;
  logic convert_start_in = 1, power_down_in = 0, local_limit = 0, sdo, limit_flag_out;
  logic chain_clock_up_out, chain_select_up_out, chain_data_up_out, chain_data_up_in;
  logic convert_start_up_out, power_down_up_out, chain_limit_up_in, write_valid;
  logic chain_data_down_out, chain_limit_down_out, conv_start, power_down;
  logic [31:0] result_word = 32'h1234_ABCD, reg_word = 32'h8765_4321, write_word;
  logic [63:0] rx;
  int error_cnt = 0, checks = 0, n_conv = 0, n_wv = 0, cyc = 0;
  initial forever #50 ref_clk = ~ref_clk;
  smc_chain_port dut (.*);
  smc_upper_model #(.WORD(UP_W)) upper (.*);
  task wrap_up(input int fail);
    error_cnt += fail;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    n_conv += int'(conv_start === 1'b1);
    n_wv += int'(write_valid === 1'b1);
    if (cyc == 5000) wrap_up(1);
  end
  task frame(input logic [31:0] w, input int n);
    @(posedge ref_clk) cs_n <= 1'b0;
    #21;
    for (int i = 0; i < n; i++) begin
      #16 sclk = 1'b1;
      sdi = (i < 32) ? w[31-i] : 1'b0;
      #12 rx = {rx[62:0], master_sel ? sdo : chain_data_down_out};
      `CHK(chain_data_up_out, ((i < 32) ? w[31-i] : 1'b0))
      #4 sclk = 1'b0;
    end
    #20 sdi = ~sdi;
    @(posedge ref_clk) cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task t_pins;
    int c;
    c = n_conv;
    @(posedge ref_clk) convert_start_in <= 1'b0;
    power_down_in <= 1'b1;
    alert_up <= 1'b1;
    repeat (8) @(negedge ref_clk);
    `CHK(n_conv, c + 1)
    `CHK(power_down, 1'b1)
    `CHK(power_down_up_out, 1'b1)
    `CHK(convert_start_up_out, 1'b0)
    `CHK(limit_flag_out, 1'b1)
    @(posedge ref_clk) convert_start_in <= 1'b1;
    power_down_in <= 1'b0;
    alert_up <= 1'b0;
  endtask
  task t_serial;
    int c;
    c = n_conv;
    frame(32'hC000_0000, 32);
    `CHK(write_word, 32'hC000_0000)
    `CHK(n_conv, c + 1)
    frame(32'h0000_0000, 64);
    `CHK(rx[63:32], reg_word)
    `CHK(rx[31:0], UP_W)
    frame(32'h0000_0000, 32);
    `CHK(rx[31:0], result_word)
    c = n_wv;
    frame(32'hFFFF_FFFF, 20);
    `CHK(n_wv, c)
    `CHK(write_word, 32'h0000_0000)
  endtask
  task t_slave;
    @(posedge ref_clk) master_sel <= 1'b0;
    local_limit <= 1'b1;
    frame(32'h4000_0000, 32);
    frame(32'h0000_0000, 64);
    `CHK(rx[63:32], reg_word)
    `CHK(rx[31:0], UP_W)
    `CHK(chain_limit_down_out, 1'b1)
    `CHK(limit_flag_out, 1'b0)
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_pins();
    t_serial();
    t_slave();
    wrap_up(0);
  end
endmodule
